// ### hdl/eew_seq.sv
// eeprom byte write sequencer with block protect
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - each byte write issued while idle that is not skipped or blocked takes a twenty millisecond programming interval
// - array reads return no valid data while a byte programs
// - skip programming when stored byte already equals requested value
// - four blocks of 32, 64, 128, 288 bytes, each write protectable
// - smaller blocks fill low 224 bytes ascending, largest covers upper 288
// - array decoded at 0xae00 through 0xafff
module eew_seq
  import eew_pkg::*;
#(
  parameter int unsigned PROG_CNT = PROG_CYCLES
)
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic o_busy
);
  eew_arr_if arr ();
  eew_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [IDX_W-1:0] widx_r, widx_nxt;
  logic [DATA_W-1:0] wdat_r, wdat_nxt;
  logic [NBLK-1:0] prot_r, prot_nxt;
  logic skip_r, skip_nxt;
  logic blocked_r, blocked_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic busy_r, busy_nxt;
  logic we;
  logic in_arr;
  logic [IDX_W-1:0] idx;
  logic blocked;

  assign in_arr = (i_addr >= ARR_BASE) && (i_addr <= ARR_LAST);
  assign idx = IDX_W'(i_addr - ARR_BASE);

  eew_prot u_prot (
    .i_idx(idx),
    .i_prot(prot_r),
    .o_blocked(blocked)
  );

  eew_array u_array (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .arr(arr)
  );

  assign arr.ridx = idx;
  assign arr.we = we;
  assign arr.widx = widx_r;
  assign arr.wdata = wdat_r;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    widx_nxt = widx_r;
    wdat_nxt = wdat_r;
    prot_nxt = prot_r;
    skip_nxt = skip_r;
    blocked_nxt = blocked_r;
    rdata_nxt = '0;
    rvalid_nxt = 1'b0;
    we = 1'b0;
    case (state_r)
      EEW_IDLE:
      begin
        if (i_wr && in_arr)
        begin
          if (blocked)
            blocked_nxt = 1'b1;
          else if (arr.rdata == i_wdata)
            skip_nxt = 1'b1;
          else
          begin
            state_nxt = EEW_PROG;
            cnt_nxt = CNT_W'(PROG_CNT - 1);
            widx_nxt = idx;
            wdat_nxt = i_wdata;
            skip_nxt = 1'b0;
            blocked_nxt = 1'b0;
          end
        end
      end
      EEW_PROG:
      begin
        if (cnt_r == '0)
        begin
          we = 1'b1;
          state_nxt = EEW_IDLE;
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      default:
        state_nxt = EEW_IDLE;
    endcase
    if (i_wr && i_addr == PROT_ADDR)
      prot_nxt = i_wdata[NBLK-1:0];
    if (i_rd)
    begin
      if (in_arr && state_r == EEW_IDLE)
      begin
        rdata_nxt = arr.rdata;
        rvalid_nxt = 1'b1;
      end
      else if (i_addr == PROT_ADDR)
      begin
        rdata_nxt = DATA_W'(prot_r);
        rvalid_nxt = 1'b1;
      end
      else if (i_addr == STAT_ADDR)
      begin
        rdata_nxt[STAT_BUSY_BIT] = busy_r;
        rdata_nxt[STAT_SKIP_BIT] = skip_r;
        rdata_nxt[STAT_BLOCKED_BIT] = blocked_r;
        rvalid_nxt = 1'b1;
      end
    end
    busy_nxt = (state_nxt == EEW_PROG);
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      state_r <= EEW_IDLE;
      cnt_r <= '0;
      widx_r <= '0;
      wdat_r <= '0;
      prot_r <= PROT_RST;
      skip_r <= 1'b0;
      blocked_r <= 1'b0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      widx_r <= widx_nxt;
      wdat_r <= wdat_nxt;
      prot_r <= prot_nxt;
      skip_r <= skip_nxt;
      blocked_r <= blocked_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_busy = busy_r;
endmodule

// ### common/eew_pkg.sv
// package of constants and types for the eeprom write sequencer
package eew_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned PROG_TIME_MS = 20;
  localparam int unsigned PROG_CYCLES = (CLK_HZ / 1000) * PROG_TIME_MS;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ARR_BYTES = 512;
  localparam int IDX_W = 9;
  localparam int CNT_W = 22;
  localparam logic [ADDR_W-1:0] ARR_BASE = 16'hae00;
  localparam logic [ADDR_W-1:0] ARR_LAST = 16'hafff;
  localparam int NBLK = 4;
  localparam logic [IDX_W-1:0] BLK0_END = 9'h020;
  localparam logic [IDX_W-1:0] BLK1_END = 9'h060;
  localparam logic [IDX_W-1:0] BLK2_END = 9'h0e0;
  localparam logic [ADDR_W-1:0] PROT_ADDR = 16'h803f;
  localparam logic [NBLK-1:0] PROT_RST = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'hff;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 16'h803e;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SKIP_BIT = 1;
  localparam int STAT_BLOCKED_BIT = 2;
  typedef enum logic [1:0] {EEW_IDLE, EEW_PROG} eew_state_t;
endpackage

// ### common/eew_arr_if.sv
// interface between sequencer and storage array
`timescale 1ns/1ps
interface eew_arr_if;
  import eew_pkg::*;
  logic we;
  logic [IDX_W-1:0] widx;
  logic [DATA_W-1:0] wdata;
  logic [IDX_W-1:0] ridx;
  logic [DATA_W-1:0] rdata;
  modport ctl (output we, output widx, output wdata, output ridx, input rdata);
  modport mem (input we, input widx, input wdata, input ridx, output rdata);
endinterface

// ### hdl/eew_array.sv
// flip-flop storage array of the eeprom
`timescale 1ns/1ps
module eew_array
  import eew_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  eew_arr_if.mem arr
);
  logic [DATA_W-1:0] mem_r [ARR_BYTES];
  genvar g;
  generate
    for (g = 0; g < ARR_BYTES; g++)
    begin : g_cell
      logic [DATA_W-1:0] cell_nxt;
      always_comb
      begin
        cell_nxt = mem_r[g];
        if (arr.we && arr.widx == IDX_W'(g))
          cell_nxt = arr.wdata;
      end
      always_ff @(posedge i_clk)
      begin
        if (i_reset)
          mem_r[g] <= DATA_RST;
        else
          mem_r[g] <= cell_nxt;
      end
    end
  endgenerate
  assign arr.rdata = mem_r[arr.ridx];
endmodule

// ### hdl/eew_prot.sv
// block protect decode
`timescale 1ns/1ps
module eew_prot
  import eew_pkg::*;
(
  input wire logic [IDX_W-1:0] i_idx,
  input wire logic [NBLK-1:0] i_prot,
  output logic o_blocked
);
  always_comb
  begin
    if (i_idx < BLK0_END)
      o_blocked = i_prot[0];
    else if (i_idx < BLK1_END)
      o_blocked = i_prot[1];
    else if (i_idx < BLK2_END)
      o_blocked = i_prot[2];
    else
      o_blocked = i_prot[3];
  end
endmodule

// ### test/eew_seq_checker.sv
// port assertions of the write sequencer
`timescale 1ns/1ps
module eew_seq_checker
  import eew_pkg::*;
#(parameter int unsigned PROG_CNT = 8)
(
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_busy
);
  wire arr = i_addr >= ARR_BASE && i_addr <= ARR_LAST;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);
  a_busy_len: assert property ($rose(o_busy) |-> o_busy[*7] ##[1:2] !o_busy) else $error("busy len");
  a_busy_cause: assert property ($rose(o_busy) |-> $past(i_wr && arr)) else $error("busy why");
  a_rd_busy: assert property (i_rd && arr && o_busy |=> !o_rvalid) else $error("busy read");
  a_rd_idle: assert property (i_rd && arr && !o_busy |=> o_rvalid) else $error("read lost");
  a_rd_quiet: assert property (!i_rd |=> !o_rvalid && o_rdata == 8'h00) else $error("stray data");
  a_wr_out: assert property (i_wr && !arr && !o_busy |=> !o_busy) else $error("stray prog");
endmodule
bind eew_seq eew_seq_checker #(.PROG_CNT(PROG_CNT)) i_chk (.I_SYS_CLK, .I_RESET, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .o_rvalid, .o_busy);

// ### test/eew_host.sv
// host core model issuing byte accesses
`timescale 1ns/1ps
module eew_host
  import eew_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_busy,
  input wire logic i_rvalid,
  input wire logic [DATA_W-1:0] i_rdata,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  logic irq_off = 1'b0;
  logic [8:0] rv;
  initial {o_addr, o_wdata, o_wr, o_rd} = '0;
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    irq_off <= 1'b1;
    @(posedge i_clk);
    o_wdata <= ~d;
    o_wr <= 1'b0;
  endtask
  // counts busy cycles over twelve clocks, interrupts held off until those twelve clocks end
  task automatic idle(output logic [8:0] n);
    n = '0;
    repeat (12)
    begin
      @(negedge i_clk);
      n += i_busy;
    end
    irq_off <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(negedge i_clk);
    rv = {i_rvalid, i_rdata};
    @(posedge i_clk);
  endtask
endmodule

// ### test/eew_seq_tb.sv
// self-checking bench of the write sequencer
`timescale 1ns/1ps
module eew_seq_tb;
  import eew_pkg::*;
  logic I_SYS_CLK = 1'b0;
  logic I_RESET = 1'b1;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic i_wr, i_rd, o_rvalid, o_busy;
  logic [8:0] n;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  always #4 I_SYS_CLK = ~I_SYS_CLK;
  eew_seq #(.PROG_CNT(8)) i_eew_seq (.I_SYS_CLK, .I_RESET, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_rvalid, .o_busy);
  eew_host i_eew_host (.i_clk(I_SYS_CLK), .i_busy(o_busy), .i_rvalid(o_rvalid), .i_rdata(o_rdata),
    .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    n_fail += cyc > 2000;
    $display("fails %0d checks %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_eew_host.wr(a, d);
    i_eew_host.idle(n);
  endtask
  task automatic t_prog();
    put(ARR_BASE, 8'h5a);
    chk(n, 9'h008);
    i_eew_host.rd(ARR_BASE);
    chk(i_eew_host.rv, 9'h15a);
    put(ARR_BASE, 8'h5a);
    chk(n, 9'h000);
  endtask
  task automatic t_busy();
    i_eew_host.wr(ARR_LAST, 8'h3c);
    i_eew_host.rd(ARR_BASE);
    chk(i_eew_host.rv, 9'h000);
    i_eew_host.idle(n);
    put(16'hadff, 8'h00);
    chk(n, 9'h000);
    i_eew_host.rd(ARR_LAST);
    chk(i_eew_host.rv, 9'h13c);
  endtask
  task automatic t_prot();
    logic [ADDR_W-1:0] st [4] = '{16'hae00, 16'hae20, 16'hae60, 16'haee0};
    for (int b = 0; b < 4; b++)
    begin
      put(PROT_ADDR, 8'h01 << b);
      put(st[b], 8'h11);
      chk(n, 9'h000);
      i_eew_host.rd(STAT_ADDR);
      chk(i_eew_host.rv, 9'h104);
      i_eew_host.rd(PROT_ADDR);
      chk(i_eew_host.rv, 9'h100 | (9'h001 << b));
      put(st[b] - 16'h1, 8'h22);
      chk(n, b ? 9'h008 : 9'h000);
    end
  endtask
  always @(posedge I_SYS_CLK)
    if (++cyc > 2000)
      give_verdict();
  initial
  begin
    repeat (10) @(posedge I_SYS_CLK);
    I_RESET <= 1'b0;
    t_prog();
    t_busy();
    t_prot();
    give_verdict();
  end
endmodule
